//--- core/bsu_pkg.sv
/*
  shared constants, types and field helpers for the bit-field scan unit.
  assumes 64-bit general registers and decoder-supplied immediates.
*/
package bsu_pkg;

  localparam int          DATA_W         = 64;
  localparam int          IDX_W          = 4;
  localparam int          LEN_W          = 7;
  localparam int          POS_W          = 6;

  // zero-scan element counts and no-hit results
  localparam int          BYTE_COUNT     = 8;
  localparam int          PAIR_COUNT     = 4;
  localparam logic [3:0]  SCAN_BYTE_NONE = 4'h8;
  localparam logic [3:0]  SCAN_PAIR_NONE = 4'h4;

  // widths of the encoded length immediates and the byte immediate
  localparam int          LEN_WIDE_W     = 6;
  localparam int          LEN_NARROW_W   = 4;
  localparam int          BYTE_IMM_W     = 8;

  localparam logic [63:0] ALL_ONES       = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] ALL_ZEROS      = 64'h0000_0000_0000_0000;
  localparam logic [6:0]  REG_BITS       = 7'h40;

  // values after reset of the writeback stage
  localparam logic [63:0] WB_DATA_RST    = 64'h0000_0000_0000_0000;
  localparam logic [6:0]  WB_DEST_RST    = 7'h00;

  typedef enum logic [2:0] {
    OP_SCAN,
    OP_DEP_MERGE_REG,
    OP_DEP_MERGE_IMM,
    OP_DEP_ZERO_REG,
    OP_DEP_ZERO_IMM,
    OP_PULL_SIGNED,
    OP_PULL_UNSIGNED
  } bsu_op_t;

  // mask of the low len bits, len 0..64
  function automatic logic [63:0] bsuLowMask(input logic [6:0] len);
    bsuLowMask = len[6] ? ALL_ONES : ~(ALL_ONES << len[5:0]);
  endfunction

  // length clipped at the register top
  function automatic logic [6:0] bsuClipLen(input logic [5:0] pos, input logic [6:0] len);
    logic [6:0] room;
    room       = REG_BITS - {1'b0, pos};
    bsuClipLen = (len > room) ? room : len;
  endfunction

endpackage

//--- core/bsu_zero_scan.sv
/*
  zero-element index finder over bytes or 16-bit pairs, either direction.
  assumes a purely combinational use inside the datapath.
*/
`timescale 1ns/1ps
`default_nettype none

module bsu_zero_scan
  import bsu_pkg::*;
#(
  parameter int SRC_W = DATA_W
) (
  // operand
  input  wire logic [SRC_W-1:0] scanSrc,
  // variant
  input  wire logic             twoByte,
  input  wire logic             fromLeft,
  // result
  output logic      [IDX_W-1:0] zeroIndex
);

  logic [BYTE_COUNT-1:0] byteZero;
  logic [PAIR_COUNT-1:0] pairZero;

  genvar gi;
  generate
    for (gi = 0; gi < BYTE_COUNT; gi++) begin : g_byte
      assign byteZero[gi] = ~|scanSrc[8*gi +: 8]; // RULE_01
    end
    for (gi = 0; gi < PAIR_COUNT; gi++) begin : g_pair
      assign pairZero[gi] = ~|scanSrc[16*gi +: 16]; // RULE_01
    end
  endgenerate

  // lowest step in scan order wins
  always_comb begin
    zeroIndex = twoByte ? SCAN_PAIR_NONE : SCAN_BYTE_NONE; // RULE_02 RULE_03
    if (twoByte) begin
      for (int k = PAIR_COUNT - 1; k >= 0; k--) begin
        if (pairZero[fromLeft ? (PAIR_COUNT - 1 - k) : k]) begin // RULE_04
          zeroIndex = IDX_W'(k); // RULE_03
        end
      end
    end else begin
      for (int k = BYTE_COUNT - 1; k >= 0; k--) begin
        if (byteZero[fromLeft ? (BYTE_COUNT - 1 - k) : k]) begin // RULE_04
          zeroIndex = IDX_W'(k); // RULE_02
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- core/bsu_field_pull.sv
/*
  field extraction with right justification and zero or sign fill.
  assumes decoded length 1..64 and position 0..63 from the caller.
*/
`timescale 1ns/1ps
`default_nettype none

module bsu_field_pull
  import bsu_pkg::*;
(
  // operand and field
  input  wire logic [DATA_W-1:0] pullSrc,
  input  wire logic [POS_W-1:0]  fieldPosition,
  input  wire logic [LEN_W-1:0]  fieldLength,
  input  wire logic              signedPull,
  // result
  output logic      [DATA_W-1:0] pulled
);

  logic [LEN_W-1:0]  effLen;
  logic [POS_W-1:0]  topIdx;
  logic              runsOver;
  logic              fillBit;
  logic [DATA_W-1:0] keepMask;

  always_comb begin
    effLen   = bsuClipLen(fieldPosition, fieldLength); // RULE_15
    runsOver = (fieldLength != effLen);
    topIdx   = POS_W'({1'b0, fieldPosition} + fieldLength - 7'h01);
    fillBit  = runsOver ? pullSrc[DATA_W-1] : pullSrc[topIdx]; // RULE_14
    keepMask = bsuLowMask(effLen);
    pulled   = ((pullSrc >> fieldPosition) & keepMask) // RULE_13
             | ({DATA_W{signedPull & fillBit}} & ~keepMask); // RULE_13
  end

endmodule

`default_nettype wire

//--- core/bsu_core.sv
/*
  bit-field scan unit: zero scan, field insert, field pull, one register
  stage ahead of register-file writeback.
  assumes operands, nat tokens and immediates come from the decoder and
  register file on clk_sys; length immediates arrive encoded as length-1.
*/
// What this block does
// [RULE_01] zero scan treats source as aligned bytes or aligned 16-bit pairs
// [RULE_02] byte scan returns first zero byte index 0-7, else 8
// [RULE_03] pair scan returns first zero pair index 0-3, else 4
// [RULE_04] left scans from top element, right from bottom; index counts scan order
// [RULE_05] merging insert places right-justified field into copy of second source
// [RULE_06] immediate merging insert uses one bit sign-extended to all 64 bits
// [RULE_07] field starts at position 0-63 and grows toward the top bit
// [RULE_08] register merge length is 1-16 from 4 bits; immediate merge 1-64
// [RULE_09] zeroing insert clears all bits outside field; length 1-64
// [RULE_10] zeroing insert field comes from register or sign-extended byte immediate
// [RULE_11] field bits past destination bit 63 are dropped
// [RULE_12] length immediates are encoded as length minus one; one is added back
// [RULE_13] pull right-justifies field, zero-filled unsigned or sign-filled signed
// [RULE_14] signed fill is field top bit, or source bit 63 when field overruns
// [RULE_15] pull length 1-64 and position 0-63 from immediates
// [RULE_16] false guard predicate leaves destination and its nat untouched
// [RULE_17] scan copies source nat; insert ORs nat of register sources used
`timescale 1ns/1ps
`default_nettype none

module bsu_core
  import bsu_pkg::*;
#(
  parameter int DEST_W = 7
) (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  // issue from the decoder
  input  wire logic                    opValid,
  input  wire bsu_op_t                 opCode,
  input  wire logic                    guardPredicate,
  input  wire logic [DEST_W-1:0]       destIndex,
  // scan variant
  input  wire logic                    scanTwoByte,
  input  wire logic                    scanLeft,
  // general register operands
  input  wire logic [DATA_W-1:0]       fieldSrc,
  input  wire logic                    fieldSrcNat,
  input  wire logic [DATA_W-1:0]       baseSrc,
  input  wire logic                    baseSrcNat,
  // immediates
  input  wire logic [POS_W-1:0]        fieldPosition,
  input  wire logic [LEN_WIDE_W-1:0]   fieldLengthWide,
  input  wire logic [LEN_NARROW_W-1:0] fieldLengthNarrow,
  input  wire logic                    oneBitImmediate,
  input  wire logic [BYTE_IMM_W-1:0]   byteImmediate,
  // writeback to the register file
  output logic                         wbEnable,
  output logic      [DEST_W-1:0]       wbDest,
  output logic      [DATA_W-1:0]       wbData,
  output logic                         wbNat
);

  // decoded lengths
  logic [LEN_W-1:0]  lenWide;
  logic [LEN_W-1:0]  lenNarrow;
  logic [LEN_W-1:0]  depLen;
  logic [LEN_W-1:0]  depEffLen;

  // insert operands
  logic [DATA_W-1:0] depSrc;
  logic [DATA_W-1:0] depBase;
  logic [DATA_W-1:0] depMask;
  logic [DATA_W-1:0] depResult;
  logic              depNat;

  // sub-unit results
  logic [IDX_W-1:0]  scanIndex;
  logic [DATA_W-1:0] pullResult;

  // selected result
  logic [DATA_W-1:0] resData;
  logic              resNat;
  logic              resLegal;

  // writeback stage
  logic              wbEnable_r;
  logic              wbEnable_nxt;
  logic [DEST_W-1:0] wbDest_r;
  logic [DEST_W-1:0] wbDest_nxt;
  logic [DATA_W-1:0] wbData_r;
  logic [DATA_W-1:0] wbData_nxt;
  logic              wbNat_r;
  logic              wbNat_nxt;

  // length decode
  always_comb begin
    lenWide   = LEN_W'(fieldLengthWide) + 7'h01; // RULE_12
    lenNarrow = LEN_W'(fieldLengthNarrow) + 7'h01; // RULE_12 RULE_08
  end

  bsu_zero_scan #(
    .SRC_W     (DATA_W)
  ) u_scan (
    .scanSrc   (baseSrc),
    .twoByte   (scanTwoByte),
    .fromLeft  (scanLeft),
    .zeroIndex (scanIndex)
  );

  bsu_field_pull u_pull (
    .pullSrc       (baseSrc),
    .fieldPosition (fieldPosition),
    .fieldLength   (lenWide),
    .signedPull    (opCode == OP_PULL_SIGNED),
    .pulled        (pullResult)
  );

  // insert operand selection
  always_comb begin
    depSrc  = fieldSrc;
    depBase = baseSrc;
    depLen  = lenWide;
    depNat  = 1'b0;
    unique case (opCode)
      OP_DEP_MERGE_REG: begin
        depLen = lenNarrow; // RULE_08
        depNat = fieldSrcNat | baseSrcNat; // RULE_17
      end
      OP_DEP_MERGE_IMM: begin
        depSrc = {DATA_W{oneBitImmediate}}; // RULE_06
        depNat = baseSrcNat; // RULE_17
      end
      OP_DEP_ZERO_REG: begin
        depBase = ALL_ZEROS; // RULE_09
        depNat  = fieldSrcNat; // RULE_17
      end
      OP_DEP_ZERO_IMM: begin
        depBase = ALL_ZEROS; // RULE_09
        depSrc  = {{(DATA_W-BYTE_IMM_W){byteImmediate[BYTE_IMM_W-1]}}, byteImmediate}; // RULE_10
      end
      default: begin
        depNat = 1'b0;
      end
    endcase
  end

  // field insert
  always_comb begin
    depEffLen = bsuClipLen(fieldPosition, depLen); // RULE_11
    depMask   = bsuLowMask(depEffLen) << fieldPosition; // RULE_07
    depResult = (depBase & ~depMask) | ((depSrc << fieldPosition) & depMask); // RULE_05
  end

  // result selection
  always_comb begin
    resData  = depResult;
    resNat   = depNat;
    resLegal = 1'b1;
    unique case (opCode)
      OP_SCAN: begin
        resData = DATA_W'(scanIndex);
        resNat  = baseSrcNat; // RULE_17
      end
      OP_DEP_MERGE_REG,
      OP_DEP_MERGE_IMM,
      OP_DEP_ZERO_REG,
      OP_DEP_ZERO_IMM: begin
        resData = depResult;
        resNat  = depNat;
      end
      OP_PULL_SIGNED,
      OP_PULL_UNSIGNED: begin
        resData = pullResult;
        resNat  = baseSrcNat;
      end
      default: begin
        resLegal = 1'b0;
      end
    endcase
  end

  // writeback stage next values
  always_comb begin
    wbEnable_nxt = opValid & guardPredicate & resLegal; // RULE_16
    wbDest_nxt   = wbDest_r;
    wbData_nxt   = wbData_r;
    wbNat_nxt    = wbNat_r;
    if (opValid && guardPredicate && resLegal) begin // RULE_16
      wbDest_nxt = destIndex;
      wbData_nxt = resData;
      wbNat_nxt  = resNat;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wbEnable_r <= 1'b0;
      wbDest_r   <= WB_DEST_RST[DEST_W-1:0];
      wbData_r   <= WB_DATA_RST;
      wbNat_r    <= 1'b0;
    end else begin
      wbEnable_r <= wbEnable_nxt;
      wbDest_r   <= wbDest_nxt;
      wbData_r   <= wbData_nxt;
      wbNat_r    <= wbNat_nxt;
    end
  end

  assign wbEnable = wbEnable_r;
  assign wbDest   = wbDest_r;
  assign wbData   = wbData_r;
  assign wbNat    = wbNat_r;

endmodule

`default_nettype wire

//--- dv/bsu_regfile_model.sv
/*
  register file model on the writeback side of the bit-field scan unit.
  assumes at most one write per cycle from the writeback port.
*/
`timescale 1ns/1ps
`default_nettype none

module bsu_regfile_model (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // writeback
  input wire logic        wbEnable,
  input wire logic [6:0]  wbDest,
  input wire logic [63:0] wbData,
  input wire logic        wbNat
);
  logic [64:0] regs [128];

  always @(posedge clk_sys) begin
    if (rstn && wbEnable) regs[wbDest] <= {wbNat, wbData};
  end
endmodule

`default_nettype wire

//--- dv/bsu_core_props.sv
/*
  checker for the writeback port of the bit-field scan unit.
  assumes it is bound to bsu_core and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module bsu_core_chk
  import bsu_pkg::*;
#(
  parameter int DEST_W = 7
) (
  // clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rstn,
  // issue
  input wire logic                  opValid,
  input wire bsu_op_t               opCode,
  input wire logic                  guardPredicate,
  input wire logic [DEST_W-1:0]     destIndex,
  input wire logic                  scanTwoByte,
  input wire logic                  baseSrcNat,
  input wire logic [POS_W-1:0]      fieldPosition,
  input wire logic [LEN_WIDE_W-1:0] fieldLengthWide,
  input wire logic                  oneBitImmediate,
  input wire logic [BYTE_IMM_W-1:0] byteImmediate,
  // writeback
  input wire logic                  wbEnable,
  input wire logic [DEST_W-1:0]     wbDest,
  input wire logic [63:0]           wbData,
  input wire logic                  wbNat
);
  wire logic go = opValid && guardPredicate;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_refuse;
    opValid && !guardPredicate |=> !wbEnable;
  endproperty
  a_refuse: assert property (p_refuse) else $error("write on false guard");
  property p_hold;
    !wbEnable |-> $stable(wbData) && $stable(wbNat);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_issue;
    go && opCode <= OP_PULL_UNSIGNED |=> wbEnable && wbDest == $past(destIndex);
  endproperty
  a_issue: assert property (p_issue) else $error("no writeback");
  property p_scanb;
    go && opCode == OP_SCAN && !scanTwoByte |=> wbData <= 64'h8;
  endproperty
  a_scanb: assert property (p_scanb) else $error("byte index range");
  property p_scanp;
    go && opCode == OP_SCAN && scanTwoByte |=> wbData <= 64'h4 && wbNat == $past(baseSrcNat);
  endproperty
  a_scanp: assert property (p_scanp) else $error("pair index range");
  property p_zimm;
    go && opCode == OP_DEP_ZERO_IMM && byteImmediate == 8'h00 |=> wbData == 64'h0 && !wbNat;
  endproperty
  a_zimm: assert property (p_zimm) else $error("zero insert");
  property p_mimm;
    go && opCode == OP_DEP_MERGE_IMM && fieldPosition == 6'h00 && fieldLengthWide == 6'h3F
      |=> wbData == {64{$past(oneBitImmediate)}};
  endproperty
  a_mimm: assert property (p_mimm) else $error("one bit fill");
  property p_pullu;
    go && opCode == OP_PULL_UNSIGNED && fieldLengthWide == 6'h00 |=> wbData[63:1] == 63'h0;
  endproperty
  a_pullu: assert property (p_pullu) else $error("pull zero fill");
endmodule

bind bsu_core bsu_core_chk #(.DEST_W(DEST_W)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .opValid(opValid), .opCode(opCode),
  .guardPredicate(guardPredicate), .destIndex(destIndex), .scanTwoByte(scanTwoByte),
  .baseSrcNat(baseSrcNat), .fieldPosition(fieldPosition), .fieldLengthWide(fieldLengthWide),
  .oneBitImmediate(oneBitImmediate), .byteImmediate(byteImmediate), .wbEnable(wbEnable),
  .wbDest(wbDest), .wbData(wbData), .wbNat(wbNat)
);

`default_nettype wire

//--- dv/bsu_core_bench.sv
/*
  self-checking bench for the bit-field scan unit with a reference model.
  assumes bsu_core, its bound checker and the register file model.
*/
`timescale 1ns/1ps
`default_nettype none

module bsu_core_bench
  import bsu_pkg::*;
;
  logic clk_sys = 1'b0, rstn = 1'b0, opValid = 1'b0, guardPredicate = 1'b0;
  logic scanTwoByte = 1'b0, scanLeft = 1'b0, fieldSrcNat = 1'b0, baseSrcNat = 1'b0;
  logic oneBitImmediate = 1'b0, wbEnable, wbNat;
  bsu_op_t opCode = OP_SCAN;
  logic [6:0] destIndex = 7'h00, wbDest;
  logic [63:0] fieldSrc = 64'h0, baseSrc = 64'h0, wbData;
  logic [5:0] fieldPosition = 6'h00, fieldLengthWide = 6'h00;
  logic [3:0] fieldLengthNarrow = 4'h0;
  logic [7:0] byteImmediate = 8'h00;
  logic [71:0] expQ [$];
  int bad_count = 0, compares = 0;

  always #5 clk_sys = ~clk_sys;

  bsu_core dut (.clk_sys(clk_sys), .rstn(rstn), .opValid(opValid), .opCode(opCode),
    .guardPredicate(guardPredicate), .destIndex(destIndex), .scanTwoByte(scanTwoByte),
    .scanLeft(scanLeft), .fieldSrc(fieldSrc), .fieldSrcNat(fieldSrcNat), .baseSrc(baseSrc),
    .baseSrcNat(baseSrcNat), .fieldPosition(fieldPosition), .fieldLengthWide(fieldLengthWide),
    .fieldLengthNarrow(fieldLengthNarrow), .oneBitImmediate(oneBitImmediate),
    .byteImmediate(byteImmediate), .wbEnable(wbEnable), .wbDest(wbDest), .wbData(wbData),
    .wbNat(wbNat));
  bsu_regfile_model rfm (.clk_sys(clk_sys), .rstn(rstn), .wbEnable(wbEnable),
    .wbDest(wbDest), .wbData(wbData), .wbNat(wbNat));

  function automatic logic [64:0] model();
    logic [63:0] m, s, r;
    int len, k, w, e;
    len = (opCode == OP_DEP_MERGE_REG) ? fieldLengthNarrow + 1 : fieldLengthWide + 1;
    m = (64'h1 << len) - 64'h1;
    if (opCode == OP_SCAN) begin
      k = scanTwoByte ? 4 : 8;
      w = 64 / k;
      r = 64'(k);
      for (int i = k - 1; i >= 0; i--) begin
        e = scanLeft ? k - 1 - i : i;
        if (((baseSrc >> (e * w)) & ((64'h1 << w) - 64'h1)) == 64'h0) r = 64'(i);
      end
      return {baseSrcNat, r};
    end
    if (opCode >= OP_PULL_SIGNED) begin
      m = m & (64'hFFFF_FFFF_FFFF_FFFF >> fieldPosition);
      r = (baseSrc >> fieldPosition) & m;
      s = (fieldPosition + len > 64) ? baseSrc >> 63 : baseSrc >> (fieldPosition + len - 1);
      if (opCode == OP_PULL_SIGNED && s[0]) r = r | ~m;
      return {baseSrcNat, r};
    end
    case (opCode)
      OP_DEP_MERGE_IMM: s = {64{oneBitImmediate}};
      OP_DEP_ZERO_IMM: s = {{56{byteImmediate[7]}}, byteImmediate};
      default: s = fieldSrc;
    endcase
    r = (opCode <= OP_DEP_MERGE_IMM) ? baseSrc & ~(m << fieldPosition) : 64'h0;
    r = r | ((s & m) << fieldPosition);
    case (opCode)
      OP_DEP_MERGE_REG: return {fieldSrcNat | baseSrcNat, r};
      OP_DEP_MERGE_IMM: return {baseSrcNat, r};
      OP_DEP_ZERO_REG: return {fieldSrcNat, r};
      default: return {1'b0, r};
    endcase
  endfunction

  task automatic chk(input logic [71:0] e, input logic [71:0] a);
    compares++;
    if (a !== e) begin
      $display("wrong value at %0t: exp %h got %h", $time, e, a);
      bad_count++;
    end
  endtask

  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic issue(input bsu_op_t op, input logic g);
    opCode = op;
    guardPredicate = g;
    destIndex = 7'($urandom);
    opValid = 1'b1;
    if (g && op <= OP_PULL_UNSIGNED) expQ.push_back({destIndex, model()});
    @(negedge clk_sys);
  endtask

  task automatic rnd();
    {fieldSrc, baseSrc} = {$urandom, $urandom, $urandom, $urandom};
    {scanTwoByte, scanLeft, fieldSrcNat, baseSrcNat, oneBitImmediate} = 5'($urandom);
    {fieldPosition, fieldLengthWide, fieldLengthNarrow, byteImmediate} = 24'($urandom);
  endtask

  task automatic drain();
    opValid = 1'b0;
    for (int i = 0; i < 10 && expQ.size() != 0; i++) @(negedge clk_sys);
    if (expQ.size() != 0) begin
      bad_count++;
      results();
    end
  endtask

  always @(negedge clk_sys) begin
    if (rstn && wbEnable === 1'b1) chk(expQ.size() != 0 ? expQ.pop_front() : 72'hX,
      {wbDest, wbNat, wbData});
  end

  initial begin
    void'($urandom(78113));
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    baseSrc = 64'h1122_0033_4455_6677;
    scanLeft = 1'b1;
    issue(OP_SCAN, 1'b1);
    byteImmediate = 8'hFF;
    fieldPosition = 6'h3C;
    fieldLengthWide = 6'h07;
    issue(OP_DEP_ZERO_IMM, 1'b1);
    baseSrc = 64'h8000_0000_0000_0000;
    issue(OP_PULL_SIGNED, 1'b1);
    for (int v = 0; v < 36; v++) begin
      rnd();
      baseSrc = baseSrc | 64'h0101_0101_0101_0101;
      {scanTwoByte, scanLeft} = 2'(v / 9);
      if (v % 9 < 8) baseSrc[(v % 9) * 8 +: 8] = 8'h00;
      if (scanTwoByte && v % 9 < 8) baseSrc[((v % 9) ^ 1) * 8 +: 8] = 8'h00;
      issue(OP_SCAN, 1'b1);
    end
    $display("scan test done");
    rnd();
    fieldPosition = 6'h00;
    fieldLengthWide = 6'h3F;
    issue(OP_DEP_MERGE_IMM, 1'b1);
    byteImmediate = 8'h00;
    fieldPosition = 6'h3F;
    issue(OP_DEP_ZERO_IMM, 1'b1);
    fieldLengthWide = 6'h00;
    issue(OP_PULL_UNSIGNED, 1'b1);
    fieldLengthNarrow = 4'hF;
    issue(OP_DEP_MERGE_REG, 1'b1);
    issue(bsu_op_t'(3'h7), 1'b1);
    issue(OP_PULL_SIGNED, 1'b0);
    $display("boundary test done");
    for (int n = 0; n < 400; n++) begin
      rnd();
      issue(bsu_op_t'(n % 8), ($urandom % 4) != 0);
    end
    drain();
    $display("random test done");
    rstn = 1'b0;
    @(negedge clk_sys);
    chk(72'h0, {wbDest, wbNat, wbData});
    rstn = 1'b1;
    rnd();
    issue(OP_SCAN, 1'b1);
    drain();
    $display("reset test done");
    results();
  end
endmodule

`default_nettype wire
